// File: hdl/vtpr_pkg.sv
// package for the video timing and pattern register block
// assumes one 40 MHz pixel clock and an AXI4-Lite register master
package vtpr_pkg;
   // register indices; the byte address is four times the index
   localparam logic [5:0] IDX_CM_TRIM = 6'h1B;
   localparam logic [5:0] IDX_LINE_LO = 6'h20;
   localparam logic [5:0] IDX_LINE_HI = 6'h21;
   localparam logic [5:0] IDX_FRAME_LO = 6'h24;
   localparam logic [5:0] IDX_FRAME_HI = 6'h25;
   localparam logic [5:0] IDX_SYNC_LO = 6'h28;
   localparam logic [5:0] IDX_SYNC_HI = 6'h29;
   localparam logic [5:0] IDX_HSW_LO = 6'h2C;
   localparam logic [5:0] IDX_HSW_HI = 6'h2D;
   localparam logic [5:0] IDX_VSW_LO = 6'h30;
   localparam logic [5:0] IDX_VSW_HI = 6'h31;
   localparam logic [5:0] IDX_HBP = 6'h34;
   localparam logic [5:0] IDX_VBP = 6'h36;
   localparam logic [5:0] IDX_HFP = 6'h38;
   localparam logic [5:0] IDX_VFP = 6'h3A;
   localparam logic [5:0] IDX_PAT = 6'h3C;
   localparam logic [5:0] IDX_POLARITY = 6'h18;
   localparam logic [5:0] IDX_STATUS = 6'h3E;
   // field positions
   localparam int CM_TRIM_LSB = 4;
   localparam int PAT_EN_BIT = 4;
   localparam int HS_LOW_BIT = 6;
   localparam int VS_LOW_BIT = 5;
   // reset values
   localparam logic [11:0] RST_LEN12 = 12'h000;
   localparam logic [9:0] RST_LEN10 = 10'h000;
   localparam logic [7:0] RST_PORCH = 8'h00;
   localparam logic [1:0] RST_CM_TRIM = 2'b00;
   localparam logic RST_PAT_EN = 1'b0;
   localparam logic RST_HS_LOW = 1'b1;
   localparam logic RST_VS_LOW = 1'b1;
   // common mode trim in signed percent
   localparam logic [3:0] CM_PCT_NONE = 4'h0;
   localparam logic [3:0] CM_PCT_DOWN3 = 4'hD;
   localparam logic [3:0] CM_PCT_UP3 = 4'h3;
   localparam logic [3:0] CM_PCT_UP6 = 4'h6;
   // timing counts in pixel clocks, then fifo depth in entries and pixel width in bits
   localparam logic [12:0] LATENCY_CYC = 13'h000A;
   localparam logic [12:0] MIN_SYNC_DELAY_CYC = 13'h0020;
   localparam int FIFO_DEPTH = 4;
   localparam int PIX_W = 24;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001, H_DELAY = 6'b000010, H_SYNC = 6'b000100,
      H_BPORCH = 6'b001000, H_ACTIVE = 6'b010000, H_FPORCH = 6'b100000
   } vtpr_hst_type;
   typedef enum logic [3:0] {
      V_SYNC = 4'b0001, V_BPORCH = 4'b0010, V_ACTIVE = 4'b0100,
      V_FPORCH = 4'b1000
   } vtpr_vst_type;
endpackage : vtpr_pkg

// File: hdl/vtpr_top.sv
// video timing registers, sync delay path and test pattern generator
// assumes pixel stream and sync pulses synchronous to SYS_CLK_I
// How it works
// - the 12-bit active line length sets the pixels of every output line
// - the 12-bit frame line count sets active lines of the test pattern only
// - while forwarding, an incoming sync is launched after the 12-bit programmed delay; an hsync is taken only in H_IDLE
// - a fixed internal latency of about ten clocks adds to that delay
// - the 10-bit hsync width sets the hsync pulse length in clocks
// - the 10-bit vsync width sets the vsync pulse length in lines
// - the horizontal back porch follows hsync before the active pixels
// - in pattern mode the vertical back porch follows vsync
// - in pattern mode the horizontal front porch follows active pixels
// - in pattern mode the vertical front porch follows active lines
// - bit 4 of the pattern control register turns the generator on
// - the generator also uses hsync width, vsync width and back porch
// - pattern-only fields never touch normal forwarding
// - the common mode trim code maps to 0, -3, +3 or +6 percent
// - hsync and vsync levels follow their own polarity bits, low default
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module vtpr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [$clog2(DEPTH):0] level_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] cnt;
      logic full;
   } vtpr_fifo_state_type;
   vtpr_fifo_state_type s_ff, nxt_s;
   logic push, pop;
   assign push = in_valid_i && !s_ff.full;
   assign pop = out_ready_i && (s_ff.cnt != '0);
   always_comb
   begin
      nxt_s = s_ff;
      if (push)
      begin
         nxt_s.mem[s_ff.wr_ptr] = in_data_i;
         nxt_s.wr_ptr = (s_ff.wr_ptr == LAST_PTR) ? '0 : s_ff.wr_ptr + 1'b1;
      end
      if (pop)
         nxt_s.rd_ptr = (s_ff.rd_ptr == LAST_PTR) ? '0 : s_ff.rd_ptr + 1'b1;
      if (push && !pop)
         nxt_s.cnt = s_ff.cnt + 1'b1;
      else if (pop && !push)
         nxt_s.cnt = s_ff.cnt - 1'b1;
      // full is a flop so the ready towards the source is glitch free
      nxt_s.full = (nxt_s.cnt == FULL_CNT);
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s_ff <= '0;
      else
         s_ff <= nxt_s;
   end
   assign in_ready_o = !s_ff.full;
   assign out_valid_o = (s_ff.cnt != '0);
   assign out_data_o = s_ff.mem[s_ff.rd_ptr];
   assign level_o = s_ff.cnt;
   a_fifo_full_stall: assert property (@(posedge clk_i) disable iff (rst_i)
      s_ff.full && !pop |=> s_ff.full && $stable(s_ff.wr_ptr))
      else $error("fifo accepted data while full");
endmodule : vtpr_fifo

module vtpr_top
   import vtpr_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   // axi4-lite write
   input wire logic [7:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // axi4-lite read
   input wire logic [7:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // incoming video stream
   input wire logic [vtpr_pkg::PIX_W-1:0] VID_PIX_I,
   input wire logic VID_PIX_VALID_I,
   output logic VID_PIX_READY_O,
   input wire logic VID_HSYNC_I,
   input wire logic VID_VSYNC_I,
   // panel side
   output logic [vtpr_pkg::PIX_W-1:0] LVDS_PIX_O,
   output logic LVDS_DE_O,
   output logic LVDS_HS_O,
   output logic LVDS_VS_O,
   output logic [3:0] CM_TRIM_PCT_O
);
   import vtpr_pkg::*;
   typedef struct packed {
      logic aw_ready;
      logic [5:0] aw_idx;
      logic w_ready;
      logic [7:0] w_byte;
      logic w_en;
      logic b_valid;
      logic [1:0] b_resp;
      logic ar_ready;
      logic r_valid;
      logic [7:0] r_byte;
      logic [1:0] r_resp;
      logic [1:0] cm_trim;
      logic [11:0] line_len;
      logic [11:0] frame_lines;
      logic [11:0] sync_dly;
      logic [9:0] hs_w;
      logic [9:0] vs_w;
      logic [7:0] hbp;
      logic [7:0] vbp;
      logic [7:0] hfp;
      logic [7:0] vfp;
      logic pat_en;
      logic hs_low;
      logic vs_low;
      logic pat_on;
      vtpr_hst_type hst;
      logic [12:0] h_cnt;
      vtpr_vst_type vst;
      logic [12:0] v_cnt;
      logic v_arm;
      logic [12:0] v_dly;
      logic vs_act;
      logic [PIX_W-1:0] pix;
      logic de;
      logic hs;
      logic vs;
      logic [3:0] cm_pct;
   } vtpr_top_state_type;
   vtpr_top_state_type s_ff, nxt_s;
   logic [PIX_W-1:0] fifo_data;
   logic fifo_valid, fifo_pop, line_start, restart, rd_hit;
   logic [2:0] fifo_level;
   logic [7:0] rd_val;
   logic [12:0] dly_cyc;
   vtpr_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .in_data_i(VID_PIX_I),
      .in_valid_i(VID_PIX_VALID_I),
      .in_ready_o(VID_PIX_READY_O),
      .out_data_o(fifo_data),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_pop),
      .level_o(fifo_level)
   );
   // software owns the 32-clock floor; no clamping here
   assign dly_cyc = {1'b0, s_ff.sync_dly} + LATENCY_CYC;
   assign restart = (s_ff.pat_en != s_ff.pat_on);
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (S_AXI_ARADDR_I[7:2])
         IDX_CM_TRIM: rd_val = 8'(s_ff.cm_trim) << CM_TRIM_LSB;
         IDX_LINE_LO: rd_val = s_ff.line_len[7:0];
         IDX_LINE_HI: rd_val = {4'h0, s_ff.line_len[11:8]};
         IDX_FRAME_LO: rd_val = s_ff.frame_lines[7:0];
         IDX_FRAME_HI: rd_val = {4'h0, s_ff.frame_lines[11:8]};
         IDX_SYNC_LO: rd_val = s_ff.sync_dly[7:0];
         IDX_SYNC_HI: rd_val = {4'h0, s_ff.sync_dly[11:8]};
         IDX_HSW_LO: rd_val = s_ff.hs_w[7:0];
         IDX_HSW_HI: rd_val = {6'h00, s_ff.hs_w[9:8]};
         IDX_VSW_LO: rd_val = s_ff.vs_w[7:0];
         IDX_VSW_HI: rd_val = {6'h00, s_ff.vs_w[9:8]};
         IDX_HBP: rd_val = s_ff.hbp;
         IDX_VBP: rd_val = s_ff.vbp;
         IDX_HFP: rd_val = s_ff.hfp;
         IDX_VFP: rd_val = s_ff.vfp;
         IDX_PAT: rd_val = 8'(s_ff.pat_en) << PAT_EN_BIT;
         IDX_POLARITY: rd_val = (8'(s_ff.hs_low) << HS_LOW_BIT)
            | (8'(s_ff.vs_low) << VS_LOW_BIT);
         IDX_STATUS: rd_val = {1'b0, fifo_level, s_ff.de, s_ff.vs_act,
            s_ff.hst == H_SYNC, s_ff.pat_on};
         default:
         begin
            rd_val = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end
   always_comb
   begin
      nxt_s = s_ff;
      fifo_pop = 1'b0;
      line_start = 1'b0;
      // write address and data are taken independently
      if (s_ff.aw_ready && S_AXI_AWVALID_I)
      begin
         nxt_s.aw_idx = S_AXI_AWADDR_I[7:2];
         nxt_s.aw_ready = 1'b0;
      end
      if (s_ff.w_ready && S_AXI_WVALID_I)
      begin
         nxt_s.w_byte = S_AXI_WDATA_I[7:0];
         nxt_s.w_en = S_AXI_WSTRB_I[0];
         nxt_s.w_ready = 1'b0;
      end
      if (!s_ff.aw_ready && !s_ff.w_ready && !s_ff.b_valid)
      begin
         nxt_s.b_valid = 1'b1;
         nxt_s.b_resp = RESP_OKAY;
         unique case (s_ff.aw_idx)
            IDX_CM_TRIM, IDX_LINE_LO, IDX_LINE_HI, IDX_FRAME_LO,
            IDX_FRAME_HI, IDX_SYNC_LO, IDX_SYNC_HI, IDX_HSW_LO, IDX_HSW_HI,
            IDX_VSW_LO, IDX_VSW_HI, IDX_HBP, IDX_VBP, IDX_HFP, IDX_VFP,
            IDX_PAT, IDX_POLARITY, IDX_STATUS: ;
            default: nxt_s.b_resp = RESP_SLVERR;
         endcase
         if (s_ff.w_en)
         begin
            unique case (s_ff.aw_idx)
               IDX_CM_TRIM: nxt_s.cm_trim = s_ff.w_byte[CM_TRIM_LSB +: 2];
               IDX_LINE_LO: nxt_s.line_len[7:0] = s_ff.w_byte;
               IDX_LINE_HI: nxt_s.line_len[11:8] = s_ff.w_byte[3:0];
               IDX_FRAME_LO: nxt_s.frame_lines[7:0] = s_ff.w_byte;
               IDX_FRAME_HI: nxt_s.frame_lines[11:8] = s_ff.w_byte[3:0];
               IDX_SYNC_LO: nxt_s.sync_dly[7:0] = s_ff.w_byte;
               IDX_SYNC_HI: nxt_s.sync_dly[11:8] = s_ff.w_byte[3:0];
               IDX_HSW_LO: nxt_s.hs_w[7:0] = s_ff.w_byte;
               IDX_HSW_HI: nxt_s.hs_w[9:8] = s_ff.w_byte[1:0];
               IDX_VSW_LO: nxt_s.vs_w[7:0] = s_ff.w_byte;
               IDX_VSW_HI: nxt_s.vs_w[9:8] = s_ff.w_byte[1:0];
               IDX_HBP: nxt_s.hbp = s_ff.w_byte;
               IDX_VBP: nxt_s.vbp = s_ff.w_byte;
               IDX_HFP: nxt_s.hfp = s_ff.w_byte;
               IDX_VFP: nxt_s.vfp = s_ff.w_byte;
               IDX_PAT: nxt_s.pat_en = s_ff.w_byte[PAT_EN_BIT];
               IDX_POLARITY:
               begin
                  nxt_s.hs_low = s_ff.w_byte[HS_LOW_BIT];
                  nxt_s.vs_low = s_ff.w_byte[VS_LOW_BIT];
               end
               default: ;
            endcase
         end
      end
      if (s_ff.b_valid && S_AXI_BREADY_I)
      begin
         nxt_s.b_valid = 1'b0;
         nxt_s.aw_ready = 1'b1;
         nxt_s.w_ready = 1'b1;
      end
      if (s_ff.ar_ready && S_AXI_ARVALID_I)
      begin
         nxt_s.ar_ready = 1'b0;
         nxt_s.r_valid = 1'b1;
         nxt_s.r_byte = rd_val;
         nxt_s.r_resp = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_ff.r_valid && S_AXI_RREADY_I)
      begin
         nxt_s.r_valid = 1'b0;
         nxt_s.ar_ready = 1'b1;
      end
      // horizontal engine, shared by forwarding and pattern modes
      unique case (s_ff.hst)
         H_IDLE:
            if (!s_ff.pat_on && VID_HSYNC_I)
            begin
               nxt_s.hst = H_DELAY;
               nxt_s.h_cnt = dly_cyc;
            end
         H_DELAY:
            if (s_ff.h_cnt <= 13'h0001)
            begin
               nxt_s.hst = H_SYNC;
               nxt_s.h_cnt = {3'b000, s_ff.hs_w};
               line_start = 1'b1;
            end
            else
               nxt_s.h_cnt = s_ff.h_cnt - 13'h0001;
         H_SYNC:
            if (s_ff.h_cnt <= 13'h0001)
            begin
               nxt_s.hst = H_BPORCH;
               nxt_s.h_cnt = {5'h00, s_ff.hbp};
            end
            else
               nxt_s.h_cnt = s_ff.h_cnt - 13'h0001;
         H_BPORCH:
            if (s_ff.h_cnt <= 13'h0001)
            begin
               nxt_s.hst = H_ACTIVE;
               nxt_s.h_cnt = {1'b0, s_ff.line_len};
            end
            else
               nxt_s.h_cnt = s_ff.h_cnt - 13'h0001;
         H_ACTIVE:
         begin
            // forwarding waits on an empty fifo instead of inventing pixels
            fifo_pop = !s_ff.pat_on && fifo_valid;
            if (s_ff.pat_on || fifo_valid)
            begin
               if (s_ff.h_cnt <= 13'h0001)
               begin
                  // only the generator owns a front porch
                  nxt_s.hst = s_ff.pat_on ? H_FPORCH : H_IDLE;
                  nxt_s.h_cnt = {5'h00, s_ff.hfp};
               end
               else
                  nxt_s.h_cnt = s_ff.h_cnt - 13'h0001;
            end
         end
         H_FPORCH:
            if (s_ff.h_cnt <= 13'h0001)
            begin
               nxt_s.hst = H_SYNC;
               nxt_s.h_cnt = {3'b000, s_ff.hs_w};
               line_start = 1'b1;
            end
            else
               nxt_s.h_cnt = s_ff.h_cnt - 13'h0001;
      endcase
      if (s_ff.pat_on && line_start)
      begin
         // frame counted in lines, same order as a line
         if (s_ff.v_cnt > 13'h0001)
            nxt_s.v_cnt = s_ff.v_cnt - 13'h0001;
         else
         begin
            unique case (s_ff.vst)
               V_SYNC:
               begin
                  nxt_s.vst = V_BPORCH;
                  nxt_s.v_cnt = {5'h00, s_ff.vbp};
               end
               V_BPORCH:
               begin
                  nxt_s.vst = V_ACTIVE;
                  nxt_s.v_cnt = {1'b0, s_ff.frame_lines};
               end
               V_ACTIVE:
               begin
                  nxt_s.vst = V_FPORCH;
                  nxt_s.v_cnt = {5'h00, s_ff.vfp};
               end
               V_FPORCH:
               begin
                  nxt_s.vst = V_SYNC;
                  nxt_s.v_cnt = {3'b000, s_ff.vs_w};
               end
            endcase
         end
      end
      if (!s_ff.pat_on)
      begin
         // forwarded vsync: delayed like hsync, then held for whole lines
         if (VID_VSYNC_I)
         begin
            nxt_s.v_arm = 1'b1;
            nxt_s.v_dly = dly_cyc;
         end
         else if (s_ff.v_arm)
         begin
            if (s_ff.v_dly <= 13'h0001)
            begin
               nxt_s.v_arm = 1'b0;
               nxt_s.vs_act = 1'b1;
               nxt_s.v_cnt = {3'b000, s_ff.vs_w};
            end
            else
               nxt_s.v_dly = s_ff.v_dly - 13'h0001;
         end
         if (s_ff.vs_act && line_start)
         begin
            if (s_ff.v_cnt <= 13'h0001)
               nxt_s.vs_act = 1'b0;
            else
               nxt_s.v_cnt = s_ff.v_cnt - 13'h0001;
         end
      end
      if (restart)
      begin
         // mode change restarts timing cleanly at a sync edge
         nxt_s.pat_on = s_ff.pat_en;
         nxt_s.hst = s_ff.pat_en ? H_SYNC : H_IDLE;
         nxt_s.h_cnt = {3'b000, s_ff.hs_w};
         nxt_s.vst = V_SYNC;
         nxt_s.v_cnt = {3'b000, s_ff.vs_w};
         nxt_s.v_arm = 1'b0;
         nxt_s.vs_act = 1'b0;
      end
      // panel outputs, one register stage after the timing state
      nxt_s.de = (s_ff.hst == H_ACTIVE) && (s_ff.pat_on
         ? (s_ff.vst == V_ACTIVE) : fifo_valid);
      nxt_s.pix = s_ff.pat_on ? {s_ff.h_cnt[7:0], s_ff.v_cnt[7:0],
         s_ff.h_cnt[7:0] ^ s_ff.v_cnt[7:0]} : fifo_data;
      nxt_s.hs = (s_ff.hst == H_SYNC) ^ s_ff.hs_low;
      nxt_s.vs = (s_ff.pat_on ? (s_ff.vst == V_SYNC) : s_ff.vs_act)
         ^ s_ff.vs_low;
      unique case (s_ff.cm_trim)
         2'b00: nxt_s.cm_pct = CM_PCT_NONE;
         2'b01: nxt_s.cm_pct = CM_PCT_DOWN3;
         2'b10: nxt_s.cm_pct = CM_PCT_UP3;
         2'b11: nxt_s.cm_pct = CM_PCT_UP6;
      endcase
   end
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         s_ff <= '0;
         s_ff.aw_ready <= 1'b1;
         s_ff.w_ready <= 1'b1;
         s_ff.ar_ready <= 1'b1;
         s_ff.cm_trim <= RST_CM_TRIM;
         s_ff.line_len <= RST_LEN12;
         s_ff.frame_lines <= RST_LEN12;
         s_ff.sync_dly <= RST_LEN12;
         s_ff.hs_w <= RST_LEN10;
         s_ff.vs_w <= RST_LEN10;
         s_ff.hbp <= RST_PORCH;
         s_ff.vbp <= RST_PORCH;
         s_ff.hfp <= RST_PORCH;
         s_ff.vfp <= RST_PORCH;
         s_ff.pat_en <= RST_PAT_EN;
         s_ff.hs_low <= RST_HS_LOW;
         s_ff.vs_low <= RST_VS_LOW;
         s_ff.hst <= H_IDLE;
         s_ff.vst <= V_SYNC;
         s_ff.hs <= RST_HS_LOW;
         s_ff.vs <= RST_VS_LOW;
      end
      else
         s_ff <= nxt_s;
   end
   assign S_AXI_AWREADY_O = s_ff.aw_ready;
   assign S_AXI_WREADY_O = s_ff.w_ready;
   assign S_AXI_BVALID_O = s_ff.b_valid;
   assign S_AXI_BRESP_O = s_ff.b_resp;
   assign S_AXI_ARREADY_O = s_ff.ar_ready;
   assign S_AXI_RVALID_O = s_ff.r_valid;
   assign S_AXI_RRESP_O = s_ff.r_resp;
   assign S_AXI_RDATA_O = {24'h00_0000, s_ff.r_byte};
   assign LVDS_PIX_O = s_ff.pix;
   assign LVDS_DE_O = s_ff.de;
   assign LVDS_HS_O = s_ff.hs;
   assign LVDS_VS_O = s_ff.vs;
   assign CM_TRIM_PCT_O = s_ff.cm_pct;
   // helper: cycles spent in the present horizontal state
   logic [12:0] st_cyc;
   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I || nxt_s.hst != s_ff.hst)
         st_cyc <= 13'h0000;
      else
         st_cyc <= st_cyc + 13'h0001;
   end
   a_sync_delay_len: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.hst == H_DELAY && nxt_s.hst == H_SYNC && !restart
      |-> st_cyc == dly_cyc - 13'h0001)
      else $error("sync delay length wrong");
   a_hsync_width_len: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.hst == H_SYNC && nxt_s.hst == H_BPORCH && !restart
      |-> st_cyc + 13'h0001 == ((s_ff.hs_w == 10'h000) ? 13'h0001
         : {3'b000, s_ff.hs_w}))
      else $error("hsync width wrong");
   a_hbp_len_check: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.hst == H_BPORCH && nxt_s.hst == H_ACTIVE && !restart
      |-> st_cyc + 13'h0001 == ((s_ff.hbp == 8'h00) ? 13'h0001
         : {5'h00, s_ff.hbp}))
      else $error("horizontal back porch wrong");
   a_hfp_len_check: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.hst == H_FPORCH && nxt_s.hst == H_SYNC && !restart
      |-> st_cyc + 13'h0001 == ((s_ff.hfp == 8'h00) ? 13'h0001
         : {5'h00, s_ff.hfp}))
      else $error("horizontal front porch wrong");
   a_pattern_line_len: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.pat_on && s_ff.hst == H_ACTIVE && nxt_s.hst == H_FPORCH
      |-> st_cyc + 13'h0001 == ((s_ff.line_len == 12'h000) ? 13'h0001
         : {1'b0, s_ff.line_len}))
      else $error("pattern line length wrong");
   a_forward_no_de: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      !s_ff.pat_on && !fifo_valid |=> !LVDS_DE_O)
      else $error("data enable without a pixel");
   a_vsync_polarity: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.pat_on && s_ff.vst == V_ACTIVE ##1 s_ff.vst == V_ACTIVE
      |-> LVDS_VS_O == $past(s_ff.vs_low))
      else $error("vsync active inside active lines");
   a_frame_order_seq: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.pat_on && $changed(s_ff.vst) && s_ff.vst == V_ACTIVE
      |-> $past(s_ff.vst) == V_BPORCH)
      else $error("active lines not after back porch");
   a_cm_trim_map: assert property (
      @(posedge SYS_CLK_I) disable iff (RST_I)
      s_ff.cm_trim == 2'b01 ##1 s_ff.cm_trim == 2'b01
      |-> CM_TRIM_PCT_O == CM_PCT_DOWN3)
      else $error("common mode trim decode wrong");
endmodule : vtpr_top

// File: tb/vtpr_src_model.sv
// source model: one line sync pulse, then a burst of pixels
// assumes the bench pulses go_i for one clock to start a line
`timescale 1ns/1ps
module vtpr_src_model (
   // control from the bench
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [3:0] count_i,
   // video towards the block
   output logic [23:0] pix_o,
   output logic valid_o,
   input wire logic ready_i,
   output logic hsync_o
);
   logic [3:0] left_ff = 4'h0;
   logic [3:0] idx_ff = 4'h0;
   initial hsync_o = 1'b0;
   // pixels only after the sync pulse; idle data differs from real data
   assign valid_o = left_ff != 4'h0;
   assign pix_o = valid_o ? {20'hA5A50, idx_ff} : {20'h5A5AF, ~idx_ff};
   always @(posedge clk_i)
   begin
      hsync_o <= go_i;
      if (hsync_o) idx_ff <= 4'h0;
      else if (valid_o && ready_i) idx_ff <= idx_ff + 4'h1;
      if (hsync_o) left_ff <= count_i;
      else if (valid_o && ready_i) left_ff <= left_ff - 4'h1;
   end
endmodule : vtpr_src_model

// File: tb/vtpr_top_tb_top.sv
// bench for the video timing and pattern register block
// assumes the source model drives pixels and one line sync pulse
`timescale 1ns/1ps
module vtpr_top_tb_top;
   import vtpr_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, go = 0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rd;
   logic vsi = 0;
   logic aw_r, w_r, bv, ar_r, rv, pv, pr, hs_i, de, hs, vs;
   logic [1:0] br, rr;
   logic [23:0] pi, po;
   logic [3:0] cm;
   int err_count = 0;
   int check_count = 0;
   vtpr_top u_vtpr_top (.SYS_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awa),
      .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(aw_r), .S_AXI_WDATA_I(wd),
      .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(w_r),
      .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(ar_r),
      .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
      .S_AXI_RREADY_I(rry), .VID_PIX_I(pi), .VID_PIX_VALID_I(pv),
      .VID_PIX_READY_O(pr), .VID_HSYNC_I(hs_i), .VID_VSYNC_I(vsi),
      .LVDS_PIX_O(po), .LVDS_DE_O(de), .LVDS_HS_O(hs), .LVDS_VS_O(vs),
      .CM_TRIM_PCT_O(cm));
   vtpr_src_model u_vtpr_src_model (.clk_i(clk), .go_i(go), .count_i(4'h4),
      .pix_o(pi), .valid_o(pv), .ready_i(pr), .hsync_o(hs_i));
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   // a wait that used its whole bound ends the run
   task automatic to(input int n);
      if (n >= 500)
      begin
         err_count++;
         test_done();
      end
   endtask : to
   task automatic wr(input logic [5:0] i, input logic [7:0] d,
      input logic [1:0] e);
      int n;
      awa <= {i, 2'b00};
      wd <= {24'h00_0000, d};
      {awv, wv, bry} <= 3'b111;
      for (n = 0; n < 500; n++)
      begin
         @(posedge clk);
         if (awv && aw_r) awv <= 1'b0;
         if (wv && w_r) wv <= 1'b0;
         if (bv) break;
      end
      to(n);
      chk(br, e);
      bry <= 1'b0;
      // one edge between calls so bready is not raised again at once
      @(posedge clk);
   endtask : wr
   task automatic rdx(input logic [5:0] i, input logic [31:0] x,
      input logic [1:0] e);
      int n;
      ara <= {i, 2'b00};
      {arv, rry} <= 2'b11;
      for (n = 0; n < 500; n++)
      begin
         @(posedge clk);
         if (arv && ar_r) arv <= 1'b0;
         if (rv) break;
      end
      to(n);
      chk(rd, x);
      chk(rr, e);
      rry <= 1'b0;
      @(posedge clk);
   endtask : rdx
   // waits for an active run, checks its first pixel and its length
   task automatic de_run(input logic cf, input logic [23:0] f, input int len);
      int n, k;
      for (n = 0; n < 500 && de !== 1'b1; n++) @(posedge clk);
      to(n);
      if (cf) chk(po, f);
      for (k = 0; k < 500 && de === 1'b1; k++) @(posedge clk);
      chk(k, len);
   endtask : de_run
   // counts blank cycles up to the next active run
   task automatic de_gap(input int len);
      int n;
      for (n = 0; n < 500 && de !== 1'b1; n++) @(posedge clk);
      chk(n, len);
   endtask : de_gap
   task automatic t_cm();
      logic [3:0] ex [4] = '{CM_PCT_NONE, CM_PCT_DOWN3, CM_PCT_UP3, CM_PCT_UP6};
      for (int c = 0; c < 4; c++)
      begin
         wr(IDX_CM_TRIM, {2'b00, c[1:0], 4'h0}, RESP_OKAY);
         repeat (2) @(posedge clk);
         chk(cm, ex[c]);
      end
   endtask : t_cm
   task automatic t_sync();
      int n;
      wr(IDX_SYNC_LO, 8'h20, RESP_OKAY);
      wr(IDX_LINE_HI, 8'h00, RESP_OKAY);
      // vsync rides with the first line only; the second line ends it
      for (int l = 0; l < 2; l++)
      begin
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         vsi <= (l == 0);
         @(posedge clk);
         vsi <= 1'b0;
         for (n = 0; n < 500 && hs_i !== 1'b1; n++) @(posedge clk);
         to(n);
         for (n = 0; n < 500 && hs === 1'b1; n++) @(posedge clk);
         chk(n, 32'd44);
         chk(vs, l);
         de_run(1'b1, 24'hA5A500, 4);
      end
   endtask : t_sync
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(hs, 1'b1);
      rdx(IDX_LINE_HI, 32'h0000_0000, RESP_OKAY);
      wr(IDX_LINE_HI, 8'hFF, RESP_OKAY);
      rdx(IDX_LINE_HI, 32'h0000_000F, RESP_OKAY);
      rdx(6'h3F, 32'h0000_0000, RESP_SLVERR);
      wr(6'h3F, 8'h11, RESP_SLVERR);
      wr(IDX_LINE_LO, 8'h04, RESP_OKAY);
      wr(IDX_HSW_LO, 8'h03, RESP_OKAY);
      wr(IDX_HBP, 8'h02, RESP_OKAY);
      t_cm();
      t_sync();
      wr(IDX_POLARITY, 8'h20, RESP_OKAY);
      chk(hs, 1'b0);
      chk(vs, 1'b1);
      wr(IDX_FRAME_LO, 8'h02, RESP_OKAY);
      wr(IDX_VBP, 8'h02, RESP_OKAY);
      wr(IDX_VFP, 8'h03, RESP_OKAY);
      wr(IDX_VSW_LO, 8'h01, RESP_OKAY);
      wr(IDX_PAT, 8'h10, RESP_OKAY);
      de_run(1'b1, 24'h04_0206, 4);
      de_gap(6);
      de_run(1'b1, 24'h04_0105, 4);
      de_gap(66);
      de_run(1'b1, 24'h04_0206, 4);
      test_done();
   end
endmodule : vtpr_top_tb_top
